/* File: dv/spwm_bank_tb.sv */
module spwm_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spwm_pkg::*;
  localparam logic [7:0] T1 = 8'h10;
  localparam logic [7:0] T2 = 8'h20;
  localparam logic [7:0] T3 = 8'h30;
  logic        clk;
  logic        srst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  pin_in, pin_out, pin_oe;
  logic [3:0]  ext_en = 4'h0;
  logic [3:0]  ext_val = 4'h0;
  int          err_count = 0;
  int          checks_done = 0;

  spwm_bank i_dut (
    .CLK(clk), .SRST(srst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TIMER_PIN_IN(pin_in), .TIMER_PIN_OUT(pin_out), .TIMER_PIN_OE(pin_oe), .IRQ(irq)
  );
  spwm_load i_load (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Starts one edge late so no signal is assigned twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'bxx;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 'x;
    r = 2'bxx;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic wo(input logic [7:0] a, input logic [31:0] dat);
    logic [1:0] r;
    wr(a, dat, r);
    chk("bresp", RESP_OKAY, r);
  endtask : wo

  task automatic rc(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
    chk("rresp", RESP_OKAY, r);
  endtask : rc

  task automatic ro(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rc(a, d);
    chk(nm, e, d);
  endtask : ro

  task automatic gap(input int i, output int n);
    logic p;
    p = pin_out[i];
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pin_out[i] === p && n < 100);
  endtask : gap

  // First gap only aligns to an edge; the next two are whole levels
  task automatic pwm_chk(input int hi, input int lo);
    int a, b, c;
    gap(1, a);
    gap(1, b);
    gap(1, c);
    chk("pwm_high", hi, pin_out[1] ? b : c);
    chk("pwm_low", lo, pin_out[1] ? c : b);
  endtask : pwm_chk

  task automatic wirq(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 70000);
  endtask : wirq

  function automatic logic [31:0] ctl(input logic [7:0] pr, input spwm_upd_t u,
    input spwm_act_t a1, input spwm_act_t a0, input spwm_rsel_t rs, input logic g,
    input logic sw, input logic en);
    spwm_ctrl_t c;
    c = '{presc: pr, rsvd: '0, gpio: g, upd: u, act1: a1, act0: a0, rsel: rs, swrst: sw, en: en};
    return c;
  endfunction : ctl

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      ro(8'(16 * i) + OFF_CTRL, CTRL_RST, "ctrl_rst");
      ro(8'(16 * i) + OFF_CNT, 32'h0, "cnt_rst");
    end
    ro(OFF_STAT, 32'h0, "stat_rst");
    ro(OFF_MASK, 32'h0, "mask_rst");
    ro(OFF_OVR, 32'h0, "ovr_rst");
    ro(OFF_PINS, 32'h0, "pins_rst");
    rd(8'h60, d, r);
    chk("unmapped_rresp", RESP_DECERR, r);
    chk("unmapped_rdata", 32'h0, d);
    wr(8'h60, 32'hffffffff, r);
    chk("unmapped_bresp", RESP_DECERR, r);
    $display("test reset done");
    wo(T1 + OFF_CMP0, 32'h4);
    wo(T1 + OFF_CMP1, 32'h2);
    wo(T1 + OFF_CTRL, ctl(8'h1, UPD_HOLD, ACT_CLR, ACT_SET, RST_CMP0, 1'b0, 1'b0, 1'b1));
    pwm_chk(6, 4);
    wo(T1 + OFF_CMP0, 32'h6);
    ro(T1 + OFF_CMP0, 32'h4, "cmp0_active");
    pwm_chk(6, 4);
    wo(T1 + OFF_CTRL, ctl(8'h1, UPD_CMP0, ACT_CLR, ACT_SET, RST_CMP0, 1'b0, 1'b0, 1'b1));
    repeat (12) @(posedge clk);
    pwm_chk(6, 8);
    ro(T1 + OFF_CMP0, 32'h6, "cmp0_loaded");
    $display("test pwm done");
    ro(OFF_STAT, 32'h30, "stat_cmp");
    chk("irq_masked", 32'h0, {31'h0, irq});
    wo(OFF_MASK, 32'h08);
    repeat (2) @(posedge clk);
    chk("irq_ovf_only", 32'h0, {31'h0, irq});
    wo(OFF_MASK, 32'h10);
    wirq(n);
    chk("irq_cmp0", 32'h1, {31'h0, n < 5});
    wo(OFF_MASK, 32'h20);
    repeat (2) @(posedge clk);
    chk("irq_cmp1", 32'h1, {31'h0, irq});
    wo(T1 + OFF_CTRL, 32'h0);
    wo(OFF_STAT, 32'h30);
    ro(OFF_STAT, 32'h0, "stat_clr");
    chk("irq_clr", 32'h0, {31'h0, irq});
    $display("test irq done");
    // Roughly 65536 cycles: the longest wait of the run
    wo(OFF_MASK, 32'h01);
    wo(OFF_CMP1, 32'h8000);
    wo(OFF_CTRL, ctl(8'h0, UPD_ANY, ACT_NONE, ACT_SET, RST_ROLL, 1'b1, 1'b1, 1'b1));
    wirq(n);
    chk("ovf_delay", 32'h1, {31'h0, n > 65525 && n < 65545});
    wo(OFF_CTRL, 32'h0);
    ro(OFF_STAT, 32'h7, "stat_ovf");
    wo(OFF_STAT, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq_ovf_clr", 32'h0, {31'h0, irq});
    $display("test overflow done");
    wo(T2 + OFF_CTRL, ctl(8'h0, UPD_HOLD, ACT_NONE, ACT_NONE, RST_SW, 1'b1, 1'b0, 1'b1));
    repeat (40) @(posedge clk);
    rc(T2 + OFF_CNT, d);
    chk("cnt_runs", 32'h1, {31'h0, d > 32'd38 && d < 32'd60});
    wo(T2 + OFF_CTRL, ctl(8'hff, UPD_HOLD, ACT_NONE, ACT_NONE, RST_SW, 1'b1, 1'b1, 1'b1));
    rc(T2 + OFF_CNT, d);
    chk("cnt_swrst", 32'h1, {31'h0, d < 32'd2});
    ro(T2 + OFF_CTRL, ctl(8'hff, UPD_HOLD, ACT_NONE, ACT_NONE, RST_SW, 1'b1, 1'b0, 1'b1),
      "swrst_clear");
    chk("oe_gpio", 32'hb, {28'h0, pin_oe});
    ext_en <= 4'h4;
    ext_val <= 4'h4;
    rc(OFF_PINS, d);
    chk("pin_c_in", 32'h1, {31'h0, d[PINS_IN_LSB + 2]});
    wo(T3 + OFF_CTRL, ctl(8'h0, UPD_HOLD, ACT_NONE, ACT_SET, RST_ROLL, 1'b0, 1'b0, 1'b1));
    repeat (4) @(posedge clk);
    chk("pin_d_out", 32'h1, {31'h0, pin_out[3]});
    rc(OFF_PINS, d);
    chk("pin_d_lvl", 32'h3, {30'h0, d[PINS_IN_LSB + 3], d[3]});
    $display("test gpio done");
    // Override enables are the complement of the timer enables, so every bit shows
    wo(OFF_GIO, 32'h45);
    for (int i = 0; i < 4; i++) begin
      wo(OFF_OVR, 32'h1 << OVR_BIT[i]);
      repeat (2) @(posedge clk);
      chk("ovr_oe", {28'h0, 4'hb ^ (4'h1 << i)}, {28'h0, pin_oe});
    end
    wo(OFF_OVR, 32'hc0060000);
    repeat (2) @(posedge clk);
    chk("ovr_out", 32'h5, {28'h0, pin_out});
    rc(OFF_PINS, d);
    chk("ovr_in", 32'h4, {28'h0, d[7:4]});
    wo(OFF_OVR, 32'h0);
    repeat (2) @(posedge clk);
    chk("ovr_off_oe", 32'hb, {28'h0, pin_oe});
    $display("test override done");
    wo(T1 + OFF_CMP0, 32'h1);
    wo(T1 + OFF_CMP1, 32'h3);
    wo(T1 + OFF_CTRL, ctl(8'h0, UPD_ANY, ACT_NONE, ACT_TOG, RST_CMP1, 1'b0, 1'b0, 1'b1));
    pwm_chk(4, 4);
    wo(T1 + OFF_CMP1, 32'h5);
    repeat (8) @(posedge clk);
    ro(T1 + OFF_CMP1, 32'h5, "cmp1_any");
    pwm_chk(6, 6);
    $display("test toggle done");
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("BAD watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule : spwm_bank_tb

/* File: dv/spwm_load.sv */
module spwm_load (
  input  wire logic [3:0] pin_out, // Drive value from the bank
  input  wire logic [3:0] pin_oe,  // Bank drives the pin
  input  wire logic [3:0] ext_en,  // Far-side driver active
  input  wire logic [3:0] ext_val, // Far-side driven level
  output logic      [3:0] pin_lvl  // Resolved level per pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-down on each pin, so a released pin never keeps its old level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b0);
    end
  end
endmodule : spwm_load

/* File: src/spwm_bank.sv */
// Operation
// - Four 16-bit counters, each stepped by its own 8-bit clock prescaler.
// - Two compare values per timer; a match drives the output event.
// - Compare writes land in a shadow while the timer runs on old values.
// - Shadow loads the active compare only on the selected compare match.
// - Counter reset source: rollover, compare equal, or software request.
// - Interrupt events: overflow and each of the two compare matches.
// - Each interrupt source has its own enable bit.
// - Compare event action on pin: set, clear, toggle or none.
// - Present output level of each timer pin is readable.
// - Pin may act as general-purpose input; its level is readable.
// - Override bits 17,18,31,30 hand pins to global I/O registers.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
module spwm_bank
  import spwm_pkg::*;
#(
  parameter int N_TMR = spwm_pkg::N_TMR_DEF,
  parameter int CNT_W = spwm_pkg::CNT_W_DEF,
  parameter int PRE_W = spwm_pkg::PRE_W_DEF
) (
  input  wire logic                      CLK,            // System clock
  input  wire logic                      SRST,           // Sync reset, high
  input  wire logic [spwm_pkg::ADDR_W-1:0] S_AXI_AWADDR, // Write address
  input  wire logic                      S_AXI_AWVALID,  // Write addr valid
  output logic                           S_AXI_AWREADY,  // Write addr ready
  input  wire logic [31:0]               S_AXI_WDATA,    // Write data
  input  wire logic [3:0]                S_AXI_WSTRB,    // Byte enables
  input  wire logic                      S_AXI_WVALID,   // Write data valid
  output logic                           S_AXI_WREADY,   // Write data ready
  output logic [1:0]                     S_AXI_BRESP,    // Write response
  output logic                           S_AXI_BVALID,   // Response valid
  input  wire logic                      S_AXI_BREADY,   // Response ready
  input  wire logic [spwm_pkg::ADDR_W-1:0] S_AXI_ARADDR, // Read address
  input  wire logic                      S_AXI_ARVALID,  // Read addr valid
  output logic                           S_AXI_ARREADY,  // Read addr ready
  output logic [31:0]                    S_AXI_RDATA,    // Read data
  output logic [1:0]                     S_AXI_RRESP,    // Read response
  output logic                           S_AXI_RVALID,   // Read data valid
  input  wire logic                      S_AXI_RREADY,   // Read data ready
  input  wire logic [N_TMR-1:0]          TIMER_PIN_IN,   // Pin levels a..d
  output logic [N_TMR-1:0]               TIMER_PIN_OUT,  // Pin drive a..d
  output logic [N_TMR-1:0]               TIMER_PIN_OE,   // Pin enable a..d
  output logic                           IRQ             // Interrupt level
);
  import spwm_pkg::*;

  localparam int NST = N_TMR * ST_PER_T;

  initial begin
    if (N_TMR < 1 || N_TMR > 4) $error("N_TMR must be 1..4");
    if (CNT_W < 2 || CNT_W > 32) $error("CNT_W must be 2..32");
    if (PRE_W != 8) $error("PRE_W must match the 8-bit presc field");
  end

  function automatic logic apply_act(input logic cur, input spwm_act_t a);
    case (a)
      ACT_SET: apply_act = 1'b1;
      ACT_CLR: apply_act = 1'b0;
      ACT_TOG: apply_act = ~cur;
      default: apply_act = cur;
    endcase
  endfunction : apply_act

  typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_RESP = 2'b10} spwm_ws_t;

  spwm_ws_t          ws_q;
  logic              aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;

  spwm_ctrl_t        ctrl_q [N_TMR];
  logic [PRE_W-1:0]  pre_q  [N_TMR];
  logic [CNT_W-1:0]  cnt_q  [N_TMR];
  logic [CNT_W-1:0]  act0_q [N_TMR];
  logic [CNT_W-1:0]  act1_q [N_TMR];
  logic [CNT_W-1:0]  shd0_q [N_TMR];
  logic [CNT_W-1:0]  shd1_q [N_TMR];
  logic [N_TMR-1:0]  lvl_q, pout_q, poe_q;
  logic [NST-1:0]    stat_q, mask_q;
  logic [31:0]       ovr_q;
  logic [31:0]       gio_q;
  logic              irq_q;

  // Write decode
  wire        wr_fire = (ws_q == WS_IDLE) && aw_have_q && w_have_q;
  wire [7:0]  wa      = 8'(aw_addr_q) & ~8'h03;
  wire        wa_tmr  = wa < TMR_SPAN;
  wire [1:0]  wa_idx  = wa[5:4];
  wire [7:0]  wa_sub  = wa & OFF_MASK_W;
  wire        wa_ok   = (wa_tmr && 32'(wa_idx) < N_TMR) || wa == OFF_STAT ||
                        wa == OFF_MASK || wa == OFF_PINS || wa == OFF_OVR ||
                        wa == OFF_GIO;
  wire [31:0] wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                         {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wdm     = w_data_q & wmask;
  wire        wr_stat = wr_fire && wa == OFF_STAT;

  // Read decode
  wire [7:0]  ra      = 8'(S_AXI_ARADDR) & ~8'h03;
  wire        ra_tmr  = ra < TMR_SPAN;
  wire [1:0]  ra_idx  = ra[5:4];
  wire [7:0]  ra_sub  = ra & OFF_MASK_W;
  wire        ra_ok   = (ra_tmr && 32'(ra_idx) < N_TMR) || ra == OFF_STAT ||
                        ra == OFF_MASK || ra == OFF_PINS || ra == OFF_OVR ||
                        ra == OFF_GIO;
  wire        rd_fire = S_AXI_ARVALID && arready_q;

  // Per-timer event wires
  logic [N_TMR-1:0] tick, m0, m1, ovf, zero, sw_rst, upd0, upd1, ovr_on;
  logic [NST-1:0]   st_set;
  logic [31:0]      rd_mux;

  always_comb begin
    st_set = '0;
    for (int i = 0; i < N_TMR; i++) begin
      sw_rst[i] = wr_fire && wa_tmr && 32'(wa_idx) == i && wa_sub == OFF_CTRL
                  && w_strb_q[0] && w_data_q[1];
      tick[i] = ctrl_q[i].en && pre_q[i] == ctrl_q[i].presc;
      m0[i]   = tick[i] && cnt_q[i] == act0_q[i];
      m1[i]   = tick[i] && cnt_q[i] == act1_q[i];
      ovf[i]  = tick[i] && &cnt_q[i];
      zero[i] = sw_rst[i] ||
                (ctrl_q[i].rsel == RST_CMP0 && m0[i]) ||
                (ctrl_q[i].rsel == RST_CMP1 && m1[i]);
      upd0[i] = (ctrl_q[i].upd == UPD_CMP0 && m0[i]) ||
                (ctrl_q[i].upd == UPD_CMP1 && m1[i]) ||
                (ctrl_q[i].upd == UPD_ANY && (m0[i] || m1[i]));
      upd1[i] = upd0[i];
      ovr_on[i] = ovr_q[OVR_BIT[i]];
      st_set[i*ST_PER_T+ST_OVF]  = ovf[i];
      st_set[i*ST_PER_T+ST_CMP0] = m0[i];
      st_set[i*ST_PER_T+ST_CMP1] = m1[i];
    end
  end

  always_comb begin
    rd_mux = '0;
    if (ra_tmr) begin
      case (ra_sub)
        OFF_CTRL: rd_mux = ctrl_q[ra_idx];
        OFF_CMP0: rd_mux = 32'(act0_q[ra_idx]);
        OFF_CMP1: rd_mux = 32'(act1_q[ra_idx]);
        OFF_CNT:  rd_mux = 32'(cnt_q[ra_idx]);
        default:  rd_mux = '0;
      endcase
    end else begin
      case (ra)
        OFF_STAT: rd_mux = 32'(stat_q);
        OFF_MASK: rd_mux = 32'(mask_q);
        OFF_PINS: rd_mux = 32'(lvl_q) | (32'(TIMER_PIN_IN) << PINS_IN_LSB);
        OFF_OVR:  rd_mux = ovr_q;
        OFF_GIO:  rd_mux = gio_q;
        default:  rd_mux = '0;
      endcase
    end
  end

  // Bus write channel
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ws_q      <= WS_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= !aw_have_q && !(S_AXI_AWVALID && awready_q) && ws_q == WS_IDLE;
      wready_q  <= !w_have_q && !(S_AXI_WVALID && wready_q) && ws_q == WS_IDLE;
      if (S_AXI_AWVALID && awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      case (ws_q)
        WS_IDLE: begin
          if (wr_fire) begin
            ws_q      <= WS_RESP;
            bvalid_q  <= 1'b1;
            bresp_q   <= wa_ok ? RESP_OKAY : RESP_DECERR;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
          end
        end
        WS_RESP: begin
          if (S_AXI_BREADY) begin
            ws_q     <= WS_IDLE;
            bvalid_q <= 1'b0;
          end
        end
        default: ws_q <= WS_IDLE;
      endcase
    end
  end

  // Bus read channel
  always_ff @(posedge CLK) begin
    if (SRST) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= !rvalid_q && !rd_fire;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= ra_ok ? rd_mux : '0;
        rresp_q  <= ra_ok ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Timers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < N_TMR; i++) begin
        ctrl_q[i] <= CTRL_RST;
        pre_q[i]  <= '0;
        cnt_q[i]  <= '0;
        act0_q[i] <= '0;
        act1_q[i] <= '0;
        shd0_q[i] <= '0;
        shd1_q[i] <= '0;
      end
      lvl_q <= '0;
    end else begin
      for (int i = 0; i < N_TMR; i++) begin
        pre_q[i] <= (tick[i] || !ctrl_q[i].en) ? '0 : pre_q[i] + 1'b1;
        if (zero[i]) cnt_q[i] <= '0;
        else if (tick[i]) cnt_q[i] <= cnt_q[i] + 1'b1;
        if (m0[i] || m1[i])
          lvl_q[i] <= apply_act(m0[i] ? apply_act(lvl_q[i], ctrl_q[i].act0)
                                      : lvl_q[i],
                                m1[i] ? ctrl_q[i].act1 : ACT_NONE);
        if (upd0[i]) act0_q[i] <= shd0_q[i];
        if (upd1[i]) act1_q[i] <= shd1_q[i];
        if (wr_fire && wa_tmr && 32'(wa_idx) == i) begin
          case (wa_sub)
            OFF_CTRL: ctrl_q[i] <= spwm_ctrl_t'((ctrl_q[i] & ~wmask) | wdm) &
                                   ~32'h0000_0002;
            OFF_CMP0: begin
              shd0_q[i] <= CNT_W'(wdm | (32'(shd0_q[i]) & ~wmask));
              if (!ctrl_q[i].en)
                act0_q[i] <= CNT_W'(wdm | (32'(shd0_q[i]) & ~wmask));
            end
            OFF_CMP1: begin
              shd1_q[i] <= CNT_W'(wdm | (32'(shd1_q[i]) & ~wmask));
              if (!ctrl_q[i].en)
                act1_q[i] <= CNT_W'(wdm | (32'(shd1_q[i]) & ~wmask));
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Global registers, interrupt and pins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stat_q <= '0;
      mask_q <= '0;
      ovr_q  <= '0;
      gio_q  <= '0;
      irq_q  <= 1'b0;
      pout_q <= '0;
      poe_q  <= '0;
    end else begin
      // Set beats a same-cycle write-one clear
      stat_q <= (stat_q & ~(wr_stat ? NST'(wdm) : '0)) | st_set;
      if (wr_fire && wa == OFF_MASK) mask_q <= NST'(wdm);
      if (wr_fire && wa == OFF_OVR)  ovr_q  <= (ovr_q & ~wmask) | wdm;
      if (wr_fire && wa == OFF_GIO)  gio_q  <= (gio_q & ~wmask) | wdm;
      irq_q <= |(stat_q & mask_q);
      for (int i = 0; i < N_TMR; i++) begin
        if (ovr_on[i]) begin
          pout_q[i] <= gio_q[i];
          poe_q[i]  <= gio_q[GIO_OE_LSB+i];
        end else begin
          pout_q[i] <= lvl_q[i];
          poe_q[i]  <= !ctrl_q[i].gpio;
        end
      end
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign TIMER_PIN_OUT = pout_q;
  assign TIMER_PIN_OE  = poe_q;
  assign IRQ           = irq_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_wrap0;
    tick[0] && &cnt_q[0] && !zero[0];
  endsequence

  counter_wrap_a: assert property (s_wrap0 |=> cnt_q[0] == '0 && stat_q[ST_OVF])
    else $error("counter did not wrap with overflow flag");
  // Every timer, so the slow-prescaler timers exercise the hold case too
  for (genvar g = 0; g < N_TMR; g++) begin : g_pre_chk
    prescale_step_a: assert property (ctrl_q[g].en && !tick[g] && !zero[g]
        |=> cnt_q[g] == $past(cnt_q[g]))
      else $error("counter moved without a prescaled tick");
  end
  cmp_flag_a: assert property (m1[0] |=> stat_q[ST_CMP1])
    else $error("compare one match not flagged");
  shadow_hold_a: assert property (ctrl_q[0].en && !upd0[0]
      |=> act0_q[0] == $past(act0_q[0]))
    else $error("active compare changed without a match");
  shadow_load_a: assert property (upd0[0] |=> act0_q[0] == $past(shd0_q[0]))
    else $error("shadow not loaded on match");
  sw_reset_a: assert property (sw_rst[0] |=> cnt_q[0] == '0)
    else $error("software reset ignored");
  irq_level_a: assert property (|(stat_q & mask_q) |=> IRQ)
    else $error("enabled event did not raise interrupt");
  irq_masked_a: assert property (!(|(stat_q & mask_q)) |=> !IRQ)
    else $error("interrupt raised with no enabled event");
  act_set_a: assert property (m0[0] && !m1[0] && ctrl_q[0].act0 == ACT_SET
      |=> lvl_q[0] ##1 TIMER_PIN_OUT[0] || ovr_on[0])
    else $error("set action did not drive pin high");
  gpio_oe_a: assert property (ctrl_q[0].gpio && !ovr_on[0] |=> !TIMER_PIN_OE[0])
    else $error("pin driven while in input mode");
  ovr_pin_a: assert property (ovr_on[0] |=> TIMER_PIN_OUT[0] == $past(gio_q[0]))
    else $error("override did not hand pin to global value");
  pin_read_a: assert property (rd_fire && ra == OFF_PINS
      |=> S_AXI_RDATA[N_TMR-1:0] == $past(lvl_q))
    else $error("pin level read-back wrong");
endmodule : spwm_bank

/* File: src/spwm_pkg.sv */
package spwm_pkg;
  localparam int N_TMR_DEF = 4;
  localparam int CNT_W_DEF = 16;
  localparam int PRE_W_DEF = 8;
  localparam int ADDR_W    = 8;
  localparam int ST_PER_T  = 3;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMP0   = 8'h04;
  localparam logic [7:0] OFF_CMP1   = 8'h08;
  localparam logic [7:0] OFF_CNT    = 8'h0c;
  localparam logic [7:0] TMR_SPAN   = 8'h40;
  localparam logic [7:0] OFF_STAT   = 8'h40;
  localparam logic [7:0] OFF_MASK   = 8'h44;
  localparam logic [7:0] OFF_PINS   = 8'h48;
  localparam logic [7:0] OFF_OVR    = 8'h4c;
  localparam logic [7:0] OFF_GIO    = 8'h50;
  localparam logic [7:0] OFF_MASK_W = 8'h0f;
  // Override bit positions of pins a..d
  localparam int OVR_BIT [4] = '{17, 18, 31, 30};
  // Status bit positions inside one timer's group
  localparam int ST_OVF  = 0;
  localparam int ST_CMP0 = 1;
  localparam int ST_CMP1 = 2;
  // Pin read-back and global I/O enable layout
  localparam int PINS_IN_LSB = 4;
  localparam int GIO_OE_LSB  = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0, ACT_SET = 2'h1, ACT_CLR = 2'h2, ACT_TOG = 2'h3
  } spwm_act_t;
  typedef enum logic [1:0] {
    RST_ROLL = 2'h0, RST_CMP0 = 2'h1, RST_CMP1 = 2'h2, RST_SW = 2'h3
  } spwm_rsel_t;
  typedef enum logic [1:0] {
    UPD_CMP0 = 2'h0, UPD_CMP1 = 2'h1, UPD_ANY = 2'h2, UPD_HOLD = 2'h3
  } spwm_upd_t;
  typedef struct packed {
    logic [7:0]  presc;
    logic [12:0] rsvd;
    logic        gpio;
    spwm_upd_t   upd;
    spwm_act_t   act1;
    spwm_act_t   act0;
    spwm_rsel_t  rsel;
    logic        swrst;
    logic        en;
  } spwm_ctrl_t;
  localparam spwm_ctrl_t CTRL_RST = '0;
endpackage : spwm_pkg
